// File: ifps_regs.vh
// Register offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef IFPS_REGS_VH
`define IFPS_REGS_VH
// Byte offsets on the APB bus
`define IFPS_OFF_CTRL     12'h000
`define IFPS_OFF_ADDR_LO  12'h004
`define IFPS_OFF_ADDR_HI  12'h008
`define IFPS_OFF_DATA0    12'h00c
`define IFPS_OFF_DATA1    12'h010
`define IFPS_OFF_DATA2    12'h014
`define IFPS_OFF_DATA3    12'h018
`define IFPS_OFF_RDATA    12'h01c
`define IFPS_OFF_CMD      12'h020
`define IFPS_OFF_STAT     12'h024
`define IFPS_OFF_IRQ_ST   12'h028
`define IFPS_OFF_IRQ_MSK  12'h02c
`define IFPS_OFF_UNLOCK   12'h030
// Main control register fields
`define IFPS_CTRL_EWEN    7
`define IFPS_CTRL_WSTART  2
`define IFPS_CTRL_RDEN    1
`define IFPS_CTRL_RSTART  0
`define IFPS_CTRL_RST     8'h00
// Command register fields
`define IFPS_CMD_ERASE    0
`define IFPS_CMD_CLRBUF   1
// Interrupt status bits
`define IFPS_IRQ_WDONE    0
`define IFPS_IRQ_RDONE    1
`define IFPS_IRQ_EDONE    2
// Unlock key value, arbitrary
`define IFPS_UNLOCK_KEY   32'h0000a5c3
// Operation times in ns and derived cycle counts at 100 ns
`define IFPS_CLK_NS       100
`define IFPS_T_WRITE_NS   2000
`define IFPS_T_ERASE_NS   3000
`define IFPS_T_READ_NS    200
`define IFPS_CYC_WRITE    ((`IFPS_T_WRITE_NS + `IFPS_CLK_NS - 1) / `IFPS_CLK_NS)
`define IFPS_CYC_ERASE    ((`IFPS_T_ERASE_NS + `IFPS_CLK_NS - 1) / `IFPS_CLK_NS)
`define IFPS_CYC_READ     ((`IFPS_T_READ_NS + `IFPS_CLK_NS - 1) / `IFPS_CLK_NS)
// Geometry
`define IFPS_BLOCK_WORDS  256
`define IFPS_UNIT_WORDS   4
`endif

// File: ifps_timer.v
// Down counter that paces one flash operation
`timescale 1ns/1ps
`default_nettype none
module ifps_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        start,
  input  wire [7:0]  load,
  output wire        busy,
  output reg         done
);
  reg [7:0] cnt_q;   // Cycles left

  // Count down once loaded, pulse done for one cycle as the count reaches zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= load;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          done <= 1'b1;
        end
      end
    end
  end

  assign busy = (cnt_q != 8'h00);
endmodule
`default_nettype wire

// File: ifps_seq.v
// In-application flash programming sequencer with APB registers and flash array
`timescale 1ns/1ps
`default_nettype none
`include "ifps_regs.vh"
//
// Contract
// - Small variant erase clears 256-word block
// - Small write programs four-word aligned unit
// - Read returns one 16-bit word
// - Large variants erase/write one page (not built here: small variant only)
// - Enabled flag rises after unlock procedure
// - Data accepted only while enabled flag high
// - Write flag held high until write done
// - Reads only when read enable set
// - Read flag held high until read done
// - Block chosen by high address bits 3:0
// - Serial programming uses clock plus data line (pins only here, protocol not modelled)
// - Control layout bits 7,2,1,0, reset zero
// - Page buffer cleared after write completes
module ifps_seq (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  input  wire        prog_serial_clock,
  input  wire        prog_serial_data_in,
  output wire        prog_serial_data_out,
  output wire        prog_serial_data_oen
);
  ////////////////////////////////////////////////////////////////////////////////
  // Flash geometry: 4K words, 16 blocks of 256, 1024 units of 4
  reg  [15:0] mem [0:4095];      // Program memory array
  reg  [7:0]  ctrl_q;            // Main flash control
  reg  [7:0]  addr_lo_q;         // Low address byte
  reg  [3:0]  addr_hi_q;         // High address nibble
  reg  [15:0] data_q [0:3];      // Four-word write unit
  reg  [15:0] rdata_q;           // Last read word
  reg  [2:0]  irq_st_q;          // Sticky events
  reg  [2:0]  irq_msk_q;         // Event mask
  reg  [1:0]  op_q;              // Running operation
  reg  [11:0] erase_base_q;      // Latched block base
  reg  [11:0] unit_base_q;       // Latched unit base
  reg  [11:0] rd_addr_q;         // Latched read address
  reg  [8:0]  wipe_q;            // Erase word index
  reg         erase_busy_q;      // Erase in progress
  wire        tmr_busy;
  wire        tmr_done;
  reg         tmr_start;
  reg  [7:0]  tmr_load;

  localparam OP_IDLE  = 2'b00;
  localparam OP_WRITE = 2'b01;
  localparam OP_READ  = 2'b10;
  localparam OP_ERASE = 2'b11;

  // Timer loads kept 32 bits wide here and cut to the timer width at use
  localparam [31:0] CYC_WRITE = `IFPS_CYC_WRITE;
  localparam [31:0] CYC_READ  = `IFPS_CYC_READ;
  localparam [31:0] CYC_ERASE = `IFPS_CYC_ERASE;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode: zero-wait, every access answered in its access cycle
  wire        acc    = psel & penable;
  wire        wr     = acc & pwrite;
  // Busy spans the erase walk as well: the walk outlasts the timer, and a
  // write finishing during it would lose its array update
  wire        busy   = (op_q != OP_IDLE) | tmr_busy | erase_busy_q;
  wire        ewen   = ctrl_q[`IFPS_CTRL_EWEN];
  wire [11:0] cur_addr = {addr_hi_q, addr_lo_q};
  reg         hit;

  // Zero-wait slave; unmapped addresses answer with an error and no effect
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign irq     = |(irq_st_q & irq_msk_q);

  // Serial programming pins: protocol not modelled, pin left undriven
  assign prog_serial_data_out = 1'b0;
  assign prog_serial_data_oen = 1'b1;

  // Address hit decode for the error response
  always @* begin
    hit = 1'b1;
    case (paddr)
      `IFPS_OFF_CTRL, `IFPS_OFF_ADDR_LO, `IFPS_OFF_ADDR_HI, `IFPS_OFF_DATA0,
      `IFPS_OFF_DATA1, `IFPS_OFF_DATA2, `IFPS_OFF_DATA3, `IFPS_OFF_RDATA,
      `IFPS_OFF_CMD, `IFPS_OFF_STAT, `IFPS_OFF_IRQ_ST, `IFPS_OFF_IRQ_MSK,
      `IFPS_OFF_UNLOCK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Registered read data, loaded in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        `IFPS_OFF_CTRL:    prdata <= {24'h000000, ctrl_q};
        `IFPS_OFF_ADDR_LO: prdata <= {24'h000000, addr_lo_q};
        `IFPS_OFF_ADDR_HI: prdata <= {28'h0000000, addr_hi_q};
        `IFPS_OFF_DATA0:   prdata <= {16'h0000, data_q[0]};
        `IFPS_OFF_DATA1:   prdata <= {16'h0000, data_q[1]};
        `IFPS_OFF_DATA2:   prdata <= {16'h0000, data_q[2]};
        `IFPS_OFF_DATA3:   prdata <= {16'h0000, data_q[3]};
        `IFPS_OFF_RDATA:   prdata <= {16'h0000, rdata_q};
        `IFPS_OFF_CMD:     prdata <= {31'h00000000, erase_busy_q};
        `IFPS_OFF_STAT:    prdata <= {30'h00000000, op_q};
        `IFPS_OFF_IRQ_ST:  prdata <= {29'h00000000, irq_st_q};
        `IFPS_OFF_IRQ_MSK: prdata <= {29'h00000000, irq_msk_q};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation timer
  // One shared timer is enough: only one operation may run at a time
  ifps_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // Start decision from a control or command write
  // Start bits decoded from the bus word itself, so the read enable must come in
  // the same write as the read start; the enabled flag is taken from the register
  wire want_w = wr & (paddr == `IFPS_OFF_CTRL) & pwdata[`IFPS_CTRL_WSTART] & ewen;
  wire want_r = wr & (paddr == `IFPS_OFF_CTRL) & pwdata[`IFPS_CTRL_RSTART]
                & pwdata[`IFPS_CTRL_RDEN];
  wire want_e = wr & (paddr == `IFPS_OFF_CMD) & pwdata[`IFPS_CMD_ERASE] & ewen;

  // Timer launch: write beats read beats erase when several ask at once
  always @* begin
    tmr_start = 1'b0;
    tmr_load  = 8'h00;
    if (!busy) begin
      // Counts are far below 256, so the low byte carries the whole value
      if (want_w) begin
        tmr_start = 1'b1;
        tmr_load  = CYC_WRITE[7:0];
      end else if (want_r) begin
        tmr_start = 1'b1;
        tmr_load  = CYC_READ[7:0];
      end else if (want_e) begin
        tmr_start = 1'b1;
        tmr_load  = CYC_ERASE[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, address, data, interrupts and operation state
  // Completion events: op_q still names the finishing operation at done,
  // so the event is decoded from it before it returns to idle
  reg [2:0] ev;
  always @* begin
    ev = 3'b000;
    if (tmr_done) begin
      case (op_q)
        OP_WRITE: ev[`IFPS_IRQ_WDONE] = 1'b1;
        OP_READ:  ev[`IFPS_IRQ_RDONE] = 1'b1;
        OP_ERASE: ev[`IFPS_IRQ_EDONE] = 1'b1;
        default:  ev = 3'b000;
      endcase
    end
  end

  integer i;
  // One process owns every register except prdata, the flash array and the erase walk state, so no flag has two drivers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q       <= `IFPS_CTRL_RST;
      addr_lo_q    <= 8'h00;
      addr_hi_q    <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        data_q[i] <= 16'h0000;
      end
      rdata_q      <= 16'h0000;
      irq_st_q     <= 3'b000;
      irq_msk_q    <= 3'b000;
      op_q         <= OP_IDLE;
      erase_base_q <= 12'h000;
      unit_base_q  <= 12'h000;
      rd_addr_q    <= 12'h000;
    end else begin
      // Events set, write-one clears; the set wins on a collision
      if (wr & (paddr == `IFPS_OFF_IRQ_ST)) begin
        irq_st_q <= (irq_st_q & ~pwdata[2:0]) | ev;
      end else begin
        irq_st_q <= irq_st_q | ev;
      end
      if (wr & (paddr == `IFPS_OFF_IRQ_MSK)) begin
        irq_msk_q <= pwdata[2:0];
      end
      // Enabled flag rises only by the unlock key
      if (wr & (paddr == `IFPS_OFF_UNLOCK) & (pwdata == `IFPS_UNLOCK_KEY)) begin
        ctrl_q[`IFPS_CTRL_EWEN] <= 1'b1;
      end
      // Control write; start bits are owned by the sequencer
      if (wr & (paddr == `IFPS_OFF_CTRL)) begin
        ctrl_q[6:3] <= pwdata[6:3];
        ctrl_q[`IFPS_CTRL_RDEN] <= pwdata[`IFPS_CTRL_RDEN];
        if (!pwdata[`IFPS_CTRL_EWEN]) begin
          ctrl_q[`IFPS_CTRL_EWEN] <= 1'b0;  // Software may relock
        end
      end
      // Address registers are frozen while an operation runs
      if (!busy & wr & (paddr == `IFPS_OFF_ADDR_LO)) begin
        addr_lo_q <= pwdata[7:0];
      end
      if (!busy & wr & (paddr == `IFPS_OFF_ADDR_HI)) begin
        addr_hi_q <= pwdata[3:0];
      end
      // Data words accepted only while enabled and idle
      for (i = 0; i < 4; i = i + 1) begin
        if (ewen & !busy & wr & (paddr == `IFPS_OFF_DATA0 + 4 * i)) begin
          data_q[i] <= pwdata[15:0];
        end
      end
      if (wr & (paddr == `IFPS_OFF_CMD) & pwdata[`IFPS_CMD_CLRBUF] & ewen & !busy) begin
        for (i = 0; i < 4; i = i + 1) begin
          data_q[i] <= 16'h0000;
        end
      end
      // Launch
      if (tmr_start) begin
        if (want_w) begin
          op_q <= OP_WRITE;
          ctrl_q[`IFPS_CTRL_WSTART] <= 1'b1;
          unit_base_q <= {cur_addr[11:2], 2'b00};
        end else if (want_r) begin
          op_q <= OP_READ;
          ctrl_q[`IFPS_CTRL_RSTART] <= 1'b1;
          rd_addr_q <= cur_addr;
        end else begin
          op_q <= OP_ERASE;
          erase_base_q <= {addr_hi_q, 8'h00};
        end
      end
      // Completion
      if (tmr_done) begin
        op_q <= OP_IDLE;
        case (op_q)
          OP_WRITE: begin
            ctrl_q[`IFPS_CTRL_WSTART] <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
              data_q[i] <= 16'h0000;
            end
          end
          OP_READ: begin
            ctrl_q[`IFPS_CTRL_RSTART] <= 1'b0;
            rdata_q <= mem[rd_addr_q];
          end
          default: begin
            op_q <= OP_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Erase walks the 256 words one per cycle; the walk outlasts the timer
  // One word per cycle keeps the erase to one array write per cycle; a unit write updates four words at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wipe_q       <= 9'h000;
      erase_busy_q <= 1'b0;
    end else if (tmr_start & !want_w & !want_r) begin
      wipe_q       <= 9'h000;
      erase_busy_q <= 1'b1;
    end else if (erase_busy_q) begin
      if (wipe_q == `IFPS_BLOCK_WORDS - 1) begin
        erase_busy_q <= 1'b0;
      end
      wipe_q <= wipe_q + 9'h001;
    end
  end

  // Array update: no reset, flash content survives
  // Writes AND into erased cells, so a write without erase cannot set bits
  integer j;                     // Unit word index of the array process
  always @(posedge pclk) begin
    if (erase_busy_q) begin
      mem[erase_base_q + {4'h0, wipe_q[7:0]}] <= 16'hffff;
    end else if (tmr_done & (op_q == OP_WRITE)) begin
      for (j = 0; j < `IFPS_UNIT_WORDS; j = j + 1) begin
        mem[unit_base_q + j[11:0]] <= mem[unit_base_q + j[11:0]] & data_q[j];
      end
    end
  end
  // A page variant would need a page buffer and page-wide array writes
  // Only the small variant is built; page mode is not present
endmodule
`default_nettype wire

// File: ifps_seq_chk.sv
// Checker of the flash sequencer bus, interrupt and pin behaviour
`timescale 1ns/1ps
`default_nettype none
`include "ifps_regs.vh"
module ifps_seq_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        prog_serial_clock,
  input wire logic        prog_serial_data_in,
  input wire logic        prog_serial_data_out,
  input wire logic        prog_serial_data_oen
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  wire acc = psel && penable;
  ////////////////////////////////////////////////////////////////////////
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_err_acc; pslverr |-> acc; endproperty
  a_err_acc: assert property (p_err_acc) else $error("pslverr outside access");
  property p_unmap; acc && !pwrite && paddr > `IFPS_OFF_UNLOCK |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_map; acc && paddr <= `IFPS_OFF_UNLOCK && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  // Programming pin is only ever listened to
  property p_oen; prog_serial_data_oen && !prog_serial_data_out; endproperty
  a_oen: assert property (p_oen)
    else $error("serial data pin driven");
  // Key write, idle, then control read shows the enabled flag
  property p_unlock; acc && pwrite && paddr == `IFPS_OFF_UNLOCK && pwdata == `IFPS_UNLOCK_KEY
    ##2 psel && !penable && !pwrite && paddr == `IFPS_OFF_CTRL ##1 acc |-> prdata[7];
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("enable flag not raised");
  property p_rd16; acc && !pwrite && paddr == `IFPS_OFF_RDATA |-> prdata[31:16] == 16'h0;
  endproperty
  a_rd16: assert property (p_rd16)
    else $error("read word wider than 16 bits");
  // Masking everything silences the line for the next two cycles
  property p_mask; acc && pwrite && paddr == `IFPS_OFF_IRQ_MSK && pwdata[2:0] == 3'h0
    |=> !irq [*2]; endproperty
  a_mask: assert property (p_mask) else $error("irq high while masked");
endmodule
`default_nettype wire

// File: tb_iap_flash_program_sequencer.sv
// Self-checking bench of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ifps_regs.vh"
module tb_iap_flash_program_sequencer;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, irq, sdo, soen, e;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  always #50 pclk = ~pclk;
  // Serial programming pins tied: protocol not modelled
  ifps_seq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .prog_serial_clock(1'b0), .prog_serial_data_in(1'b1),
    .prog_serial_data_out(sdo), .prog_serial_data_oen(soen));
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(q, exp);
  endtask
  // Watchdog bounds every poll
  task poll(input logic [11:0] a, input int b);
    do apb(1'b0, a, 32'h0); while (q[b] !== 1'b0);
  endtask
  task rdmem(input logic [11:0] fa, input logic [31:0] exp);
    apb(1'b1, `IFPS_OFF_ADDR_HI, {28'h0, fa[11:8]});
    apb(1'b1, `IFPS_OFF_ADDR_LO, {24'h0, fa[7:0]});
    apb(1'b1, `IFPS_OFF_CTRL, 32'h83);
    poll(`IFPS_OFF_CTRL, 0);
    rd(`IFPS_OFF_RDATA, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_enable;
    rd(`IFPS_OFF_CTRL, 32'h0);
    rd(`IFPS_OFF_STAT, 32'h0);
    apb(1'b1, `IFPS_OFF_DATA0, 32'h1234);
    rd(`IFPS_OFF_DATA0, 32'h0);
    apb(1'b1, `IFPS_OFF_UNLOCK, `IFPS_UNLOCK_KEY);
    rd(`IFPS_OFF_CTRL, 32'h80);
  endtask
  // Low address is junk on purpose: only the high nibble picks the block
  task t_erase(input logic [3:0] hi);
    apb(1'b1, `IFPS_OFF_ADDR_HI, {28'h0, hi});
    apb(1'b1, `IFPS_OFF_ADDR_LO, 32'h55);
    apb(1'b1, `IFPS_OFF_CMD, 32'h1);
    poll(`IFPS_OFF_CMD, 0);
  endtask
  task t_write(input logic [11:0] fa, input logic [31:0] base);
    for (int i = 0; i < 4; i++) apb(1'b1, `IFPS_OFF_DATA0 + 12'(4 * i), base ^ i);
    apb(1'b1, `IFPS_OFF_ADDR_HI, {28'h0, fa[11:8]});
    apb(1'b1, `IFPS_OFF_ADDR_LO, {24'h0, fa[7:0]});
    apb(1'b1, `IFPS_OFF_CTRL, 32'h84);
    rd(`IFPS_OFF_CTRL, 32'h84);
    apb(1'b1, `IFPS_OFF_CTRL, 32'h83);
    rd(`IFPS_OFF_STAT, 32'h1);
    poll(`IFPS_OFF_CTRL, 2);
    cmp(q & 32'h5, 32'h0);
    rd(`IFPS_OFF_DATA0, 32'h0);
    for (int i = 0; i < 4; i++) rdmem({fa[11:2], 2'h0} + 12'(i), base ^ i);
  endtask
  // Read start without read enable leaves the last word
  task t_rden;
    apb(1'b1, `IFPS_OFF_CTRL, 32'h81);
    repeat (5) @(posedge pclk);
    rd(`IFPS_OFF_RDATA, 32'h1230);
    apb(1'b1, `IFPS_OFF_CTRL, 32'h80);
  endtask
  task t_irq;
    rd(`IFPS_OFF_IRQ_ST, 32'h7);
    apb(1'b1, `IFPS_OFF_IRQ_MSK, 32'h1);
    #1 cmp({31'h0, irq}, 32'h1);
    apb(1'b1, `IFPS_OFF_IRQ_MSK, 32'h0);
    #1 cmp({31'h0, irq}, 32'h0);
    apb(1'b1, `IFPS_OFF_IRQ_MSK, 32'h1);
    apb(1'b1, `IFPS_OFF_IRQ_ST, 32'h1);
    #1 cmp({31'h0, irq}, 32'h0);
    rd(`IFPS_OFF_IRQ_ST, 32'h6);
    rd(12'h040, 32'h0);
    cmp({31'h0, e}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results;
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_enable;
    t_erase(4'h3);
    rdmem(12'h300, 32'hffff);
    rdmem(12'h3ff, 32'hffff);
    t_write(12'h306, 32'h1230);
    t_erase(4'h2);
    rdmem(12'h200, 32'hffff);
    rdmem(12'h2ff, 32'hffff);
    rdmem(12'h304, 32'h1230);
    t_rden;
    t_irq;
    results;
  end
endmodule
bind ifps_seq ifps_seq_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .prog_serial_clock(prog_serial_clock),
  .prog_serial_data_in(prog_serial_data_in), .prog_serial_data_out(prog_serial_data_out),
  .prog_serial_data_oen(prog_serial_data_oen));
`default_nettype wire
